// >>> design/epf_pkg.sv
package epf_pkg;

    localparam int DATA_W        = 16;
    localparam int VAL_W         = 18;
    localparam int NUM_BANKS_DEF = 4;
    localparam int BANK_CH_DEF   = 16;
    localparam int GROUP_CH      = 8;
    localparam int GROUP_ROUND   = 7;
    localparam int STAMP_WORDS   = 2;
    localparam int ADC_W         = 12;
    localparam int LIB_W         = 5;

    // Header word layout
    localparam int               PTYPE_LSB   = 13;
    localparam logic [2:0]       PTYPE_EVENT = 3'h4;
    localparam int               OOR_BIT     = 12;
    localparam int               ERR_BIT     = 11;
    localparam int               RSV_LSB     = 6;
    localparam logic [4:0]       RSV_VALUE   = 5'h00;
    localparam int               MATCH_BIT   = 5;
    localparam int               LIB_LSB     = 0;

    typedef enum logic [1:0]
    {
        FMT_SM17   = 2'h0,
        FMT_FULL16 = 2'h1,
        FMT_HALF16 = 2'h2
    } epf_fmt_e;

    // Clamp limits in the 18-bit input domain
    localparam logic [VAL_W-1:0]        SM_MAX_HI = 18'h0FFFF;
    localparam logic [VAL_W-1:0]        SM_MAX_LO = 18'h03FFF;
    localparam logic signed [VAL_W-1:0] TC_MAX_HI = 18'sh07FFF;
    localparam logic signed [VAL_W-1:0] TC_MIN_HI = 18'sh38000;
    localparam logic signed [VAL_W-1:0] TC_MAX_LO = 18'sh03FFF;
    localparam logic signed [VAL_W-1:0] TC_MIN_LO = 18'sh3C000;

    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'h0,
        ST_HEAD  = 4'h1,
        ST_SIG   = 4'h3,
        ST_SIGN  = 4'h2,
        ST_RANGE = 4'h6,
        ST_TSL   = 4'h7,
        ST_TSH   = 4'h5,
        ST_BWL   = 4'h4,
        ST_BWH   = 4'hC,
        ST_ADC   = 4'hD,
        ST_EXT   = 4'hF
    } epf_state_e;

    // Register map
    localparam int          ADDR_W     = 12;
    localparam logic [11:0] CTRL_ADDR  = 12'h000;
    localparam logic [11:0] BANK_ADDR  = 12'h004;
    localparam logic [11:0] STAT_ADDR  = 12'h008;
    localparam logic [11:0] CNT_ADDR   = 12'h00C;
    localparam int          CTRL_FMT   = 0;
    localparam int          CTRL_RANGE = 2;
    localparam int          CTRL_STAMP = 3;
    localparam int          CTRL_BOX   = 4;
    localparam int          CTRL_ADC   = 5;
    localparam int          CTRL_EXT   = 6;
    localparam int          CTRL_FILT  = 7;
    localparam logic [7:0]  CTRL_RESET = 8'h01;
    localparam int          BANK_FLD_W = 8;
    localparam int          STAT_BUSY  = 16;

endpackage

// >>> design/epf_sample_fmt.sv
`timescale 1ns/100ps

module epf_sample_fmt #(
    parameter bit HI_RES = 1'b1
) (
    input  wire logic signed [epf_pkg::VAL_W-1:0]  val_in,
    input  wire logic [1:0]                        fmt_in,
    output logic [epf_pkg::DATA_W-1:0]             word_out
);

    logic [epf_pkg::VAL_W-1:0]        mag;
    logic [epf_pkg::VAL_W-1:0]        sm_max;
    logic signed [epf_pkg::VAL_W-1:0] scaled;
    logic signed [epf_pkg::VAL_W-1:0] tc_max;
    logic signed [epf_pkg::VAL_W-1:0] tc_min;
    logic signed [epf_pkg::VAL_W-1:0] clamped;

    always_comb
    begin
        mag    = val_in[epf_pkg::VAL_W-1] ? epf_pkg::VAL_W'(-val_in) : epf_pkg::VAL_W'(val_in);
        sm_max = HI_RES ? epf_pkg::SM_MAX_HI : epf_pkg::SM_MAX_LO;
        tc_max = HI_RES ? epf_pkg::TC_MAX_HI : epf_pkg::TC_MAX_LO;
        tc_min = HI_RES ? epf_pkg::TC_MIN_HI : epf_pkg::TC_MIN_LO;
        // Half scale keeps the fine LSB; full scale halves the value, in the high-resolution build only
        if (HI_RES && fmt_in != epf_pkg::FMT_HALF16)
            scaled = val_in >>> 1;
        else
            scaled = val_in;
        if (scaled > tc_max)
            clamped = tc_max;
        else if (scaled < tc_min)
            clamped = tc_min;
        else
            clamped = scaled;
        if (fmt_in == epf_pkg::FMT_SM17)
            word_out = (mag > sm_max) ? sm_max[epf_pkg::DATA_W-1:0] : mag[epf_pkg::DATA_W-1:0];
        else
            word_out = clamped[epf_pkg::DATA_W-1:0];
    end

endmodule

// >>> design/epf_framer.sv
`timescale 1ns/100ps

module epf_framer #(
    parameter int NUM_BANKS = epf_pkg::NUM_BANKS_DEF,
    parameter int BANK_CH   = epf_pkg::BANK_CH_DEF,
    parameter bit HI_RES    = 1'b1
) (
    input  wire logic                                      sys_clk_in,
    input  wire logic                                      rst_b_in,
    input  wire logic [epf_pkg::ADDR_W-1:0]                paddr_in,
    input  wire logic                                      psel_in,
    input  wire logic                                      penable_in,
    input  wire logic                                      pwrite_in,
    input  wire logic [31:0]                               pwdata_in,
    input  wire logic [3:0]                                pstrb_in,
    output logic [31:0]                                    prdata_out,
    output logic                                           pready_out,
    output logic                                           pslverr_out,
    input  wire logic                                      evt_valid_in,
    output logic                                           evt_ready_out,
    input  wire logic [NUM_BANKS*BANK_CH*epf_pkg::VAL_W-1:0] ch_value_in,
    input  wire logic [NUM_BANKS*BANK_CH-1:0]              ch_over_in,
    input  wire logic [NUM_BANKS*BANK_CH-1:0]              ch_under_in,
    input  wire logic [NUM_BANKS*BANK_CH-1:0]              ch_err_in,
    input  wire logic                                      filter_match_in,
    input  wire logic [epf_pkg::LIB_W-1:0]                 filter_lib_in,
    input  wire logic [31:0]                               timestamp_in,
    input  wire logic [31:0]                               boxcar_in,
    input  wire logic [epf_pkg::ADC_W-1:0]                 adc_sample_in,
    input  wire logic [15:0]                               ext_word_in,
    output logic [epf_pkg::DATA_W-1:0]                     pkt_data_out,
    output logic                                           pkt_valid_out,
    output logic                                           pkt_last_out,
    input  wire logic                                      pkt_ready_in
);

    localparam int  NUM_CH      = NUM_BANKS * BANK_CH;
    localparam int  CW          = $clog2(BANK_CH + 1);
    localparam int  BKW         = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1;
    localparam bit  EXT_PRESENT = (NUM_BANKS > 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers and APB slave

    logic [7:0]    ctrl;
    logic [CW-1:0] cfg_nc [NUM_BANKS];
    logic [15:0]   pkt_len;
    logic [31:0]   pkt_count;
    logic          busy;
    logic          apb_access;
    logic          apb_commit;
    logic [31:0]   next_rdata;
    logic          next_err;

    assign apb_access = psel_in && penable_in && !pready_out;
    assign apb_commit = psel_in && penable_in && pready_out;

    function automatic logic [CW-1:0] clamp_nc(input logic [epf_pkg::BANK_FLD_W-1:0] v);
        return (int'(v) > BANK_CH) ? CW'(BANK_CH) : CW'(v);
    endfunction

    function automatic logic [CW-1:0] groups_of(input logic [CW-1:0] n);
        return CW'((int'(n) + epf_pkg::GROUP_ROUND) / epf_pkg::GROUP_CH);
    endfunction

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        unique case (paddr_in)
            epf_pkg::CTRL_ADDR: next_rdata = {24'h00_0000, ctrl};
            epf_pkg::BANK_ADDR:
            begin
                for (int b = 0; b < NUM_BANKS && b < 4; b++)
                    next_rdata[b*epf_pkg::BANK_FLD_W +: epf_pkg::BANK_FLD_W] = epf_pkg::BANK_FLD_W'(cfg_nc[b]);
            end
            epf_pkg::STAT_ADDR: next_rdata = {15'h0000, busy, pkt_len};
            epf_pkg::CNT_ADDR:  next_rdata = pkt_count;
            default:            next_err = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end
        else
        begin
            pready_out  <= apb_access;
            prdata_out  <= (apb_access && !pwrite_in) ? next_rdata : 32'h0000_0000;
            pslverr_out <= apb_access && next_err;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ctrl <= epf_pkg::CTRL_RESET;
            for (int b = 0; b < NUM_BANKS; b++)
                cfg_nc[b] <= CW'(BANK_CH);
        end
        else if (apb_commit && pwrite_in)
        begin
            if (paddr_in == epf_pkg::CTRL_ADDR && pstrb_in[0])
                ctrl <= pwdata_in[7:0];
            if (paddr_in == epf_pkg::BANK_ADDR)
            begin
                for (int b = 0; b < NUM_BANKS && b < 4; b++)
                    if (pstrb_in[b])
                        cfg_nc[b] <= clamp_nc(pwdata_in[b*epf_pkg::BANK_FLD_W +: epf_pkg::BANK_FLD_W]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Packet length from the live configuration

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            pkt_len <= 16'h0000;
        else
        begin
            automatic int len = 1;
            automatic int fr  = int'(ctrl[1:0] == epf_pkg::FMT_SM17) + int'(ctrl[epf_pkg::CTRL_RANGE]);
            for (int b = 0; b < NUM_BANKS; b++)
                len = len + int'(cfg_nc[b]) + int'(groups_of(cfg_nc[b])) * fr;
            len = len + epf_pkg::STAMP_WORDS * int'(ctrl[epf_pkg::CTRL_STAMP])
                      + epf_pkg::STAMP_WORDS * int'(ctrl[epf_pkg::CTRL_BOX])
                      + int'(ctrl[epf_pkg::CTRL_ADC])
                      + int'(EXT_PRESENT && ctrl[epf_pkg::CTRL_EXT]);
            pkt_len <= 16'(len);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event snapshot

    logic signed [epf_pkg::VAL_W-1:0] val_q [NUM_CH];
    logic [NUM_CH-1:0]                over_q;
    logic [NUM_CH-1:0]                under_q;
    logic [CW-1:0]                    nc_q [NUM_BANKS];
    logic [7:0]                       cfg_q;
    logic [15:0]                      hdr_q;
    logic [31:0]                      ts_q;
    logic [31:0]                      bw_q;
    logic [epf_pkg::ADC_W-1:0]        adc_q;
    logic [15:0]                      ext_q;
    logic [NUM_CH-1:0]                used;
    logic                             capture;

    assign capture = evt_valid_in && evt_ready_out;

    always_comb
    begin
        used = '0;
        for (int b = 0; b < NUM_BANKS; b++)
            for (int c = 0; c < BANK_CH; c++)
                used[b*BANK_CH+c] = (c < int'(cfg_nc[b]));
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (capture)
        begin
            for (int i = 0; i < NUM_CH; i++)
                val_q[i] <= ch_value_in[i*epf_pkg::VAL_W +: epf_pkg::VAL_W];
            over_q  <= ch_over_in;
            under_q <= ch_under_in;
            nc_q    <= cfg_nc;
            cfg_q   <= ctrl;
            ts_q    <= timestamp_in;
            bw_q    <= boxcar_in;
            adc_q   <= adc_sample_in;
            ext_q   <= ext_word_in;
            hdr_q[epf_pkg::PTYPE_LSB +: 3]  <= epf_pkg::PTYPE_EVENT;
            hdr_q[epf_pkg::OOR_BIT]         <= |((ch_over_in | ch_under_in) & used);
            hdr_q[epf_pkg::ERR_BIT]         <= |(ch_err_in & used);
            hdr_q[epf_pkg::RSV_LSB +: 5]    <= epf_pkg::RSV_VALUE;
            hdr_q[epf_pkg::MATCH_BIT]       <= ctrl[epf_pkg::CTRL_FILT] && filter_match_in;
            hdr_q[epf_pkg::LIB_LSB +: epf_pkg::LIB_W] <= filter_lib_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Packet sequencer

    epf_pkg::epf_state_e state;
    epf_pkg::epf_state_e nxt;
    logic [BKW-1:0]      bank_q;
    logic [CW-1:0]       pos_q;
    logic [BKW-1:0]      nbank;
    logic [CW-1:0]       npos;
    logic [15:0]         cur_word;
    logic [15:0]         sec_en;
    logic [15:0]         fmt_word;
    logic [CW-1:0]       limit;
    logic                advance;
    int                  first_bank;
    int                  later_bank;
    int                  ch_sel;

    function automatic epf_pkg::epf_state_e succ(input epf_pkg::epf_state_e s);
        unique case (s)
            epf_pkg::ST_IDLE:  return epf_pkg::ST_HEAD;
            epf_pkg::ST_HEAD:  return epf_pkg::ST_SIG;
            epf_pkg::ST_SIG:   return epf_pkg::ST_SIGN;
            epf_pkg::ST_SIGN:  return epf_pkg::ST_RANGE;
            epf_pkg::ST_RANGE: return epf_pkg::ST_TSL;
            epf_pkg::ST_TSL:   return epf_pkg::ST_TSH;
            epf_pkg::ST_TSH:   return epf_pkg::ST_BWL;
            epf_pkg::ST_BWL:   return epf_pkg::ST_BWH;
            epf_pkg::ST_BWH:   return epf_pkg::ST_ADC;
            epf_pkg::ST_ADC:   return epf_pkg::ST_EXT;
            default:           return epf_pkg::ST_IDLE;
        endcase
    endfunction

    // Skips sections whose words are switched off
    function automatic epf_pkg::epf_state_e next_sec(input epf_pkg::epf_state_e s, input logic [15:0] en);
        epf_pkg::epf_state_e n;
        n = succ(s);
        for (int i = 0; i < 10; i++)
            if (!en[n])
                n = succ(n);
        return n;
    endfunction

    // Lowest bank at or after 'from' that holds channels; NUM_BANKS if none
    function automatic int find_bank(input int from);
        int res;
        res = NUM_BANKS;
        for (int b = NUM_BANKS - 1; b >= 0; b--)
            if (b >= from && nc_q[b] != '0)
                res = b;
        return res;
    endfunction

    always_comb
    begin
        sec_en                    = '0;
        sec_en[epf_pkg::ST_IDLE]  = 1'b1;
        sec_en[epf_pkg::ST_HEAD]  = 1'b1;
        sec_en[epf_pkg::ST_SIG]   = find_bank(0) < NUM_BANKS;
        sec_en[epf_pkg::ST_SIGN]  = sec_en[epf_pkg::ST_SIG] && cfg_q[1:0] == epf_pkg::FMT_SM17;
        sec_en[epf_pkg::ST_RANGE] = sec_en[epf_pkg::ST_SIG] && cfg_q[epf_pkg::CTRL_RANGE];
        sec_en[epf_pkg::ST_TSL]   = cfg_q[epf_pkg::CTRL_STAMP];
        sec_en[epf_pkg::ST_TSH]   = cfg_q[epf_pkg::CTRL_STAMP];
        sec_en[epf_pkg::ST_BWL]   = cfg_q[epf_pkg::CTRL_BOX];
        sec_en[epf_pkg::ST_BWH]   = cfg_q[epf_pkg::CTRL_BOX];
        sec_en[epf_pkg::ST_ADC]   = cfg_q[epf_pkg::CTRL_ADC];
        sec_en[epf_pkg::ST_EXT]   = EXT_PRESENT && cfg_q[epf_pkg::CTRL_EXT];
    end

    assign ch_sel = int'(bank_q) * BANK_CH + int'(pos_q);

    epf_sample_fmt #(
        .HI_RES   (HI_RES)
    ) u_fmt (
        .val_in   (val_q[ch_sel]),
        .fmt_in   (cfg_q[1:0]),
        .word_out (fmt_word)
    );

    always_comb
    begin
        first_bank = find_bank(0);
        later_bank = find_bank(int'(bank_q) + 1);
        limit      = (state == epf_pkg::ST_SIG) ? nc_q[bank_q] : groups_of(nc_q[bank_q]);
        nxt        = state;
        nbank      = bank_q;
        npos       = CW'(pos_q + 1'b1);
        cur_word   = 16'h0000;
        unique case (state)
            epf_pkg::ST_HEAD:  cur_word = hdr_q;
            epf_pkg::ST_SIG:   cur_word = fmt_word;
            epf_pkg::ST_SIGN, epf_pkg::ST_RANGE:
            begin
                // Bits of channels beyond the bank's count are zero; readers ignore them
                for (int i = 0; i < epf_pkg::GROUP_CH; i++)
                begin
                    automatic int c = int'(pos_q) * epf_pkg::GROUP_CH + i;
                    if (c < int'(nc_q[bank_q]))
                    begin
                        automatic int ch = int'(bank_q) * BANK_CH + c;
                        if (state == epf_pkg::ST_SIGN)
                            cur_word[i] = val_q[ch][epf_pkg::VAL_W-1];
                        else
                            cur_word[2*i +: 2] = {under_q[ch], over_q[ch]};
                    end
                end
            end
            epf_pkg::ST_TSL:   cur_word = ts_q[15:0];
            epf_pkg::ST_TSH:   cur_word = ts_q[31:16];
            epf_pkg::ST_BWL:   cur_word = bw_q[15:0];
            epf_pkg::ST_BWH:   cur_word = bw_q[31:16];
            epf_pkg::ST_ADC:   cur_word = {4'h0, adc_q};
            epf_pkg::ST_EXT:   cur_word = ext_q;
            default:           cur_word = 16'h0000;
        endcase
        if (state == epf_pkg::ST_SIG || state == epf_pkg::ST_SIGN || state == epf_pkg::ST_RANGE)
        begin
            if (npos < limit)
                nxt = state;
            else if (later_bank < NUM_BANKS)
            begin
                nbank = BKW'(later_bank);
                npos  = '0;
            end
            else
            begin
                nxt   = next_sec(state, sec_en);
                nbank = BKW'(first_bank);
                npos  = '0;
            end
        end
        else if (state != epf_pkg::ST_IDLE)
        begin
            nxt   = next_sec(state, sec_en);
            nbank = BKW'(first_bank);
            npos  = '0;
        end
    end

    assign advance = !pkt_valid_out || pkt_ready_in;

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state         <= epf_pkg::ST_IDLE;
            bank_q        <= '0;
            pos_q         <= '0;
            evt_ready_out <= 1'b0;
        end
        else if (state == epf_pkg::ST_IDLE)
        begin
            evt_ready_out <= !capture;
            if (capture)
                state <= epf_pkg::ST_HEAD;
        end
        else if (advance)
        begin
            state         <= nxt;
            bank_q        <= nbank;
            pos_q         <= npos;
            evt_ready_out <= (nxt == epf_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pkt_data_out  <= 16'h0000;
            pkt_valid_out <= 1'b0;
            pkt_last_out  <= 1'b0;
        end
        else if (advance)
        begin
            pkt_valid_out <= (state != epf_pkg::ST_IDLE);
            pkt_data_out  <= cur_word;
            pkt_last_out  <= (state != epf_pkg::ST_IDLE) && (nxt == epf_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pkt_count <= 32'h0000_0000;
            busy      <= 1'b0;
        end
        else
        begin
            busy <= (state != epf_pkg::ST_IDLE) || pkt_valid_out;
            if (pkt_valid_out && pkt_ready_in && pkt_last_out)
                pkt_count <= pkt_count + 32'h0000_0001;
        end
    end

endmodule

// >>> dv/epf_framer_sva.sv
`timescale 1ns/100ps
module epf_framer_chk (
    input wire logic        sys_clk_in,
    input wire logic        rst_b_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        evt_valid_in,
    input wire logic        evt_ready_out,
    input wire logic [15:0] pkt_data_out,
    input wire logic        pkt_valid_out,
    input wire logic        pkt_last_out,
    input wire logic        pkt_ready_in
);
    logic hdr_q;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    // Next offered word opens a packet
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
        if (!rst_b_in)
            hdr_q <= 1'b1;
        else if (pkt_valid_out && pkt_ready_in)
            hdr_q <= pkt_last_out;
    ////////////////////////////////////////////////////////////////
    hdr_type_a: assert property (pkt_valid_out && hdr_q |-> pkt_data_out[15:13] == 3'h4)
        else $error("header type wrong");
    hdr_rsv_a: assert property (pkt_valid_out && hdr_q |-> pkt_data_out[10:6] == 5'h00)
        else $error("header reserved bits set");
    stall_hold_a: assert property (pkt_valid_out && !pkt_ready_in |=> $stable(pkt_data_out)
        && pkt_valid_out && $stable(pkt_last_out))
        else $error("word lost in stall");
    busy_hold_a: assert property (pkt_valid_out && !pkt_last_out |-> !evt_ready_out)
        else $error("event taken mid packet");
    take_drop_a: assert property (evt_valid_in && evt_ready_out |=> !evt_ready_out)
        else $error("ready stayed high after take");
    hdr_time_a: assert property (evt_valid_in && evt_ready_out && !pkt_valid_out |-> ##2 pkt_valid_out && hdr_q)
        else $error("header late");
    apb_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("apb answer late");
    pready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("pready longer than a cycle");
    rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0)
        else $error("read data outside answer");
    err_ready_a: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
endmodule
bind epf_framer epf_framer_chk chk (.sys_clk_in, .rst_b_in, .psel_in, .penable_in, .prdata_out, .pready_out,
    .pslverr_out, .evt_valid_in, .evt_ready_out, .pkt_data_out, .pkt_valid_out, .pkt_last_out, .pkt_ready_in);

// >>> dv/epf_sink.sv
`timescale 1ns/100ps
module epf_sink (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic [15:0] data_in,
    input  wire logic        valid_in,
    input  wire logic        last_in,
    input  wire logic        stall_in,
    output logic             ready_out
);
    logic [15:0] got[$];
    int          pkts = 0;
    // Every other cycle refused while stalling
    always @(posedge sys_clk_in or negedge rst_b_in)
        if (!rst_b_in)
            ready_out <= 1'b0;
        else
            ready_out <= stall_in ? ~ready_out : 1'b1;
    // Words kept raw, bits of unused channels left uninterpreted
    always @(posedge sys_clk_in)
        if (rst_b_in && valid_in && ready_out)
        begin
            got.push_back(data_in);
            if (last_in)
                pkts++;
        end
endmodule

// >>> dv/epf_framer_test.sv
`timescale 1ns/100ps
module epf_framer_test;
    localparam int NC = 8;
    logic              sys_clk_in = 1'b0, rst_b_in = 1'b0, stall = 1'b0;
    logic              psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, evt_valid_in = 1'b0;
    logic              filter_match_in = 1'b1, pready_out, pslverr_out, evt_ready_out;
    logic              pkt_valid_out, pkt_last_out, pkt_ready_in;
    logic [11:0]       paddr_in = 12'h000, adc_sample_in = 12'hABC;
    logic [3:0]        pstrb_in = 4'hF;
    logic [4:0]        filter_lib_in = 5'h00;
    logic [31:0]       pwdata_in = 32'h0, prdata_out, timestamp_in = 32'h12345678, boxcar_in = 32'hA0B0C0D0;
    logic [NC*18-1:0]  ch_value_in = '0;
    logic [NC-1:0]     ch_over_in = '0, ch_under_in = '0, ch_err_in = '0;
    logic [15:0]       ext_word_in = 16'h0000, pkt_data_out, exp_q[$];
    int                fails = 0, checks_done = 0;
    always #5 sys_clk_in = ~sys_clk_in;
    epf_framer #(.NUM_BANKS(1), .BANK_CH(NC), .HI_RES(1'b1)) dut (.sys_clk_in, .rst_b_in, .paddr_in, .psel_in,
        .penable_in, .pwrite_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .evt_valid_in,
        .evt_ready_out, .ch_value_in, .ch_over_in, .ch_under_in, .ch_err_in, .filter_match_in, .filter_lib_in,
        .timestamp_in, .boxcar_in, .adc_sample_in, .ext_word_in, .pkt_data_out, .pkt_valid_out, .pkt_last_out,
        .pkt_ready_in);
    epf_sink sink (.sys_clk_in, .rst_b_in, .data_in(pkt_data_out), .valid_in(pkt_valid_out),
        .last_in(pkt_last_out), .stall_in(stall), .ready_out(pkt_ready_in));
    ////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("Checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits for a rising edge that samples the flag high, gives up after a bound
    task automatic await(ref logic f);
        int n;
        for (n = 0; n < 300; n++)
        begin
            @(posedge sys_clk_in);
            if (f === 1'b1)
                break;
        end
        if (n == 300)
        begin
            fails++;
            test_done();
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge sys_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        await(pready_out);
        r = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic rchk(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
        input logic ee);
        logic [31:0] r;
        logic        er;
        apb(wr, a, d, r, er);
        if (!wr)
            chk(r, e);
        chk({31'h0, er}, {31'h0, ee});
    endtask
    task automatic run_event();
        int p, n;
        p = sink.pkts;
        sink.got.delete();
        @(posedge sys_clk_in);
        evt_valid_in <= 1'b1;
        await(evt_ready_out);
        evt_valid_in <= 1'b0;
        for (n = 0; n < 300 && sink.pkts == p; n++)
            @(negedge sys_clk_in);
        if (sink.pkts == p)
        begin
            fails++;
            test_done();
        end
        chk(32'(sink.got.size()), 32'(exp_q.size()));
        foreach (exp_q[i])
            chk({16'h0, sink.got[i]}, {16'h0, exp_q[i]});
    endtask
    task automatic t_minimal();
        rchk(1'b0, 12'h000, 32'h0, 32'h01, 1'b0);
        rchk(1'b0, 12'h008, 32'h0, 32'd9, 1'b0);
        rchk(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
        for (int i = 1; i < 6; i++)
            ch_value_in[i*18 +: 18] <= 18'(i * 256);
        ch_value_in[17:0] <= 18'h1FFFF;
        ch_value_in[6*18 +: 18] <= 18'h20000;
        ch_value_in[7*18 +: 18] <= 18'h3FE00;
        stall <= 1'b1;
        exp_q = '{16'h8000, 16'h7FFF, 16'h0080, 16'h0100, 16'h0180, 16'h0200, 16'h0280, 16'h8000, 16'hFF00};
        run_event();
        $display("minimal packet done");
    endtask
    task automatic t_full();
        rchk(1'b1, 12'h000, 32'hBC, 32'h0, 1'b0);
        rchk(1'b1, 12'h004, 32'h05, 32'h0, 1'b0);
        rchk(1'b0, 12'h008, 32'h0, 32'd13, 1'b0);
        for (int i = 0; i < NC; i++)
            ch_value_in[i*18 +: 18] <= 18'((i % 2) ? -(i * 256) : i * 256);
        ch_over_in <= 8'h42;
        ch_under_in <= 8'h08;
        ch_err_in <= 8'h04;
        filter_lib_in <= 5'h03;
        stall <= 1'b0;
        exp_q = '{16'h9823, 16'h0000, 16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h000A, 16'h0084,
            16'h5678, 16'h1234, 16'hC0D0, 16'hA0B0, 16'h0ABC};
        run_event();
        $display("full packet done");
    endtask
    task automatic t_half();
        rchk(1'b1, 12'h000, 32'h02, 32'h0, 1'b0);
        rchk(1'b0, 12'h008, 32'h0, 32'h6, 1'b0);
        exp_q = '{16'h9803, 16'h0000, 16'hFF00, 16'h0200, 16'hFD00, 16'h0400};
        run_event();
        rchk(1'b0, 12'h00C, 32'h0, 32'h3, 1'b0);
        $display("half scale packet done");
    endtask
    initial
    begin
        repeat (12) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        t_minimal();
        t_full();
        t_half();
        test_done();
    end
endmodule
